// ---- common/spi_frame_consts.svh ----
/*
 * timing counts, field positions and reset values for the serial frame readout block.
 * assumes inclusion by bare name from design files.
 */
`ifndef SPI_FRAME_CONSTS_SVH
`define SPI_FRAME_CONSTS_SVH

`define CLK_PERIOD_NS      10
`define DRH_WIDTH_NS       400
`define DRH_WIDTH_CYC      ((`DRH_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMEOUT_US         1000
`define TIMEOUT_CYC        ((`TIMEOUT_US * 1000) / `CLK_PERIOD_NS)
`define CMD_READ_OP        3'h5
`define CMD_WRITE_OP       3'h3
`define CMD_NOP            16'h0000
`define CMD_RESET          16'h0011
`define CMD_LOCK           16'h0555
`define CMD_UNLOCK         16'h0655
`define CRC_SEED           16'hffff
`define CRC_POLY_CCITT     16'h1021
`define CRC_POLY_ANSI      16'h8005
`define AUX_SEQ_BASE       7'h10
`define NORMAL_WORDS       6'h04
`define RESP_NOP           4'h0
`define RESP_READ_OK       4'h5
`define RESP_CRC_FAIL      4'hf

`endif

// ---- common/spi_frame_pkg.sv ----
/*
 * types shared by the serial frame readout block.
 * assumes the consts header supplies numbers.
 */
package spi_frame_pkg;
    typedef struct packed {
        logic [23:0] chan_a;
        logic [23:0] chan_b;
        logic [1:0]  cnt_a;
        logic [1:0]  cnt_b;
    } conv_result_s;

    typedef struct packed {
        logic [2:0] op;
        logic [7:0] addr;
        logic [4:0] count_m1;
    } read_cmd_s;

    typedef enum logic [1:0] {
        CMD_KIND_NOP,
        CMD_KIND_READ,
        CMD_KIND_WRITE,
        CMD_KIND_OTHER
    } cmd_kind_e;
endpackage

// ---- rtl/link_sampler.sv ----
/*
 * two-flop synchroniser for the serial clock, select and data pins, edge finder for clock and select only.
 * assumes all three pins are asynchronous to clk_sys.
 */
`timescale 1ns/100ps
module link_sampler (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic sclk_pin,
    input  wire logic cs_low_pin,
    input  wire logic sdi_pin,
    output logic      sclk_rise,
    output logic      sclk_fall,
    output logic      cs_low_level,
    output logic      cs_fall,
    output logic      cs_rise,
    output logic      sdi_level
);
    logic [2:0] sclk_sync;
    logic [2:0] cs_sync;
    logic [1:0] sdi_sync;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sclk_sync <= 3'h0;
            cs_sync   <= 3'h7;
            sdi_sync  <= 2'h0;
        end else begin
            sclk_sync <= {sclk_sync[1:0], sclk_pin};
            cs_sync   <= {cs_sync[1:0], cs_low_pin};
            sdi_sync  <= {sdi_sync[0], sdi_pin};
        end
    end

    // only stages 1 and 2 are looked at; stage 0 feeds stage 1 alone
    assign sclk_rise    = sclk_sync[1] & ~sclk_sync[2];
    assign sclk_fall    = ~sclk_sync[1] & sclk_sync[2];
    assign cs_low_level = ~cs_sync[2];
    assign cs_fall      = ~cs_sync[1] & cs_sync[2];
    assign cs_rise      = cs_sync[1] & ~cs_sync[2];
    assign sdi_level    = sdi_sync[1];
endmodule // link_sampler

// ---- rtl/adc_spi_frame_readout_control.sv ----
/*
 * device-side serial frame logic: command decode, register readback frame,
 * clock count and select timeout faults, conversion buffering and data ready.
 * assumes a host master drives clock and select; clock mode 1 (shift on rise, sample on fall).
 */
`timescale 1ns/100ps
`include "spi_frame_consts.svh"

module adc_spi_frame_readout_control #(
    parameter int TIMEOUT_CYCLES = `TIMEOUT_CYC
) (
    input  wire logic                        clk_sys,
    input  wire logic                        sys_rst,
    input  wire logic                        sclk_pin,
    input  wire logic                        chip_select_low,
    input  wire logic                        sdi_pin,
    output logic                             sdo_pin,
    output logic                             data_ready_out,
    input  wire logic                        word_len_32,
    input  wire logic                        crc_ansi,
    input  wire logic                        clock_counter_en,
    input  wire logic                        timeout_en,
    input  wire logic                        data_ready_source_select,
    input  wire logic                        conv_done_a,
    input  wire logic                        conv_done_b,
    input  wire spi_frame_pkg::conv_result_s conv_in,
    input  wire logic                        conversion_start_bit,
    output logic [7:0]                       reg_addr,
    input  wire logic [15:0]                 reg_data,
    input  wire logic                        reg_valid,
    output logic                             clock_count_fault_flag,
    output logic                             select_timeout_fault_flag,
    output logic                             lock_pulse,
    output logic                             unlock_pulse,
    output logic                             reset_pulse,
    output logic                             write_exec_pulse,
    output logic [15:0]                      write_cmd_word,
    output logic [3:0]                       cmd_response
);
    logic        sclk_rise, sclk_fall, cs_low, cs_fall, cs_rise, sdi;
    logic [5:0]  bit_idx;
    logic [5:0]  word_idx;
    logic [31:0] sh_in;
    logic [31:0] sh_out;
    logic [15:0] crc_in, crc_out;
    logic [15:0] cmd_word;
    logic [10:0] clk_cnt;
    logic [10:0] exp_cnt;
    logic        exp_valid;
    logic        timed_out;
    logic [31:0] to_cnt;
    logic        cmd_ok;
    logic        cmd_crc_ok;
    logic        read_pending;
    spi_frame_pkg::read_cmd_s read_cmd;
    logic        read_frame;
    logic [5:0]  data_words_in;
    logic        chan_b_done;
    logic        frame_done;
    logic        busy_read;
    spi_frame_pkg::conv_result_s out_buf, hold_buf;
    logic        hold_valid;
    logic        drdy_pulse_pend;
    logic [7:0]  drh_cnt;
    logic        start_seen;
    logic [15:0] wdata_crc_start;

    link_sampler u_sampler (
        .clk_sys      (clk_sys),
        .sys_rst      (sys_rst),
        .sclk_pin     (sclk_pin),
        .cs_low_pin   (chip_select_low),
        .sdi_pin      (sdi_pin),
        .sclk_rise    (sclk_rise),
        .sclk_fall    (sclk_fall),
        .cs_low_level (cs_low),
        .cs_fall      (cs_fall),
        .cs_rise      (cs_rise),
        .sdi_level    (sdi)
    );

    // one bit step of the selected polynomial
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b, input logic ansi);
        logic fb;
        fb = c[15] ^ b;
        crc_step = {c[14:0], 1'b0} ^ (fb ? (ansi ? `CRC_POLY_ANSI : `CRC_POLY_CCITT) : 16'h0000);
    endfunction

    function automatic logic [5:0] last_bit(input logic w32);
        last_bit = w32 ? 6'd31 : 6'd23;
    endfunction

    logic [5:0] wlen;
    logic       word_end;
    logic       active;
    assign wlen     = last_bit(word_len_32);
    assign word_end = sclk_fall && bit_idx == wlen;
    assign active   = cs_low && !timed_out;

    // msb-aligned 16-bit field of the word whose last bit is now arriving
    logic [15:0] rx_top;
    assign rx_top = word_len_32 ? sh_in[30:15] : sh_in[22:7];

    // readback word layout: value, address, padding
    function automatic logic [31:0] reg_word(input logic [15:0] v, input logic ok, input logic [7:0] a);
        reg_word = ok ? {v, a, 8'h00} : 32'h0000_0000;
    endfunction

    // bit and word position, shift registers and crcs
    always_ff @(posedge clk_sys) begin
        if (sys_rst || cs_fall) begin
            bit_idx  <= 6'h00;
            word_idx <= 6'h00;
            crc_in   <= `CRC_SEED;
            crc_out  <= `CRC_SEED;
            sh_in    <= 32'h0;
        end else if (active && sclk_fall) begin
            sh_in  <= {sh_in[30:0], sdi};
            crc_in <= (word_idx == 6'h01 || cmd_word[15:13] == `CMD_WRITE_OP
                       && word_idx == {3'h0, cmd_word[2:0]} + 6'h03) ? crc_in : crc_step(crc_in, sdi, crc_ansi);
            if (word_end) begin
                bit_idx  <= 6'h00;
                word_idx <= word_idx + 6'h01;
                if (word_idx == 6'h01)
                    crc_in <= `CRC_SEED;
            end else begin
                bit_idx <= bit_idx + 6'h01;
            end
        end else if (active && sclk_rise) begin
            crc_out <= crc_step(crc_out, sh_out[31], crc_ansi);
        end
    end

    // output word selection and shift, mode 1: change on rising edge
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sh_out  <= 32'h0;
            sdo_pin <= 1'b0;
        end else if (cs_fall) begin
            sh_out  <= {4'h0, cmd_response, 8'h00, hold_valid, 15'h0};
            sdo_pin <= 1'b0;
        end else if (active && sclk_rise) begin
            sdo_pin <= sh_out[31];
            sh_out  <= {sh_out[30:0], 1'b0};
        end else if (active && word_end) begin
            if (read_frame && word_idx <= {1'b0, read_cmd.count_m1})
                sh_out <= reg_word(reg_data, reg_valid, reg_addr);
            else if (!read_frame && word_idx == 6'h00)
                sh_out <= {out_buf.chan_a, 8'h00};
            else if (!read_frame && word_idx == 6'h01)
                sh_out <= {out_buf.chan_b, 8'h00};
            else if (word_idx + 6'h01 == (read_frame && read_cmd.count_m1 > 5'h01
                                          ? {1'b0, read_cmd.count_m1} + 6'h02 : 6'h03))
                sh_out <= {crc_out, 16'h0000};
            else
                sh_out <= 32'h0;
        end
    end

    // register address feed for readback, ascending from the start address
    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            reg_addr <= 8'h00;
        else if (cs_fall)
            reg_addr <= read_cmd.addr;
        else if (active && word_end && read_frame)
            reg_addr <= reg_addr + 8'h01;
    end

    // command capture at end of command word, crc check at end of command crc word
    always_ff @(posedge clk_sys) begin
        if (sys_rst || cs_fall) begin
            cmd_word   <= `CMD_NOP;
            cmd_crc_ok <= 1'b0;
        end else if (active && word_end && word_idx == 6'h00) begin
            cmd_word <= rx_top;
        end else if (active && word_end && word_idx == 6'h01) begin
            cmd_crc_ok <= rx_top == crc_in;
        end
    end

    logic [15:0] cmd_now;
    assign cmd_now = cmd_word;

    // executes lock and unlock after command and crc, reset at end of word 3; read queued for next frame
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            read_pending  <= 1'b0;
            read_cmd      <= '0;
            read_frame    <= 1'b0;
            lock_pulse    <= 1'b0;
            unlock_pulse  <= 1'b0;
            reset_pulse   <= 1'b0;
            cmd_response  <= `RESP_NOP;
            cmd_ok        <= 1'b0;
        end else begin
            lock_pulse   <= 1'b0;
            unlock_pulse <= 1'b0;
            reset_pulse  <= 1'b0;
            if (cs_fall) begin
                read_frame   <= read_pending;
                read_pending <= 1'b0;
                cmd_ok       <= 1'b0;
            end else if (cs_low && !timed_out && word_end && word_idx == 6'h01) begin
                if (rx_top != crc_in) begin
                    cmd_response <= `RESP_CRC_FAIL;
                end else if (read_frame) begin
                    cmd_response <= `RESP_NOP;
                end else if (cmd_now[15:13] == `CMD_READ_OP) begin
                    read_cmd     <= {cmd_now[15:13], cmd_now[12:5], cmd_now[4:0]};
                    read_pending <= 1'b1;
                    cmd_response <= `RESP_READ_OK;
                end else if (cmd_now == `CMD_LOCK) begin
                    lock_pulse   <= 1'b1;
                    cmd_response <= 4'h1;
                end else if (cmd_now == `CMD_UNLOCK) begin
                    unlock_pulse <= 1'b1;
                    cmd_response <= 4'h2;
                end else begin
                    cmd_response <= `RESP_NOP;
                    cmd_ok       <= 1'b1;
                end
            end else if (cs_low && !timed_out && cmd_ok && cmd_now == `CMD_RESET && word_end
                         && word_idx == 6'h03) begin
                reset_pulse  <= 1'b1;
                cmd_response <= 4'h3;
            end
        end
    end

    // write command: needs data words and data crc
    always_ff @(posedge clk_sys) begin
        if (sys_rst || cs_fall) begin
            write_exec_pulse <= 1'b0;
            write_cmd_word   <= 16'h0000;
            start_seen       <= 1'b0;
            wdata_crc_start  <= `CRC_SEED;
        end else begin
            write_exec_pulse <= 1'b0;
            if (active && word_end && cmd_ok && cmd_now[15:13] == `CMD_WRITE_OP && !read_frame
                && word_idx == {3'h0, cmd_now[2:0]} + 6'h03) begin
                write_exec_pulse <= (rx_top == crc_in);
                write_cmd_word   <= cmd_now;
                start_seen       <= conversion_start_bit && (rx_top == crc_in);
            end
        end
    end

    // expected clock count, fixed after command crc word
    assign data_words_in = (cmd_now[15:13] == `CMD_WRITE_OP) ? {3'h0, cmd_now[2:0]} + 6'h04 : `NORMAL_WORDS;
    always_ff @(posedge clk_sys) begin
        if (sys_rst || cs_fall) begin
            exp_cnt   <= 11'h0;
            exp_valid <= 1'b0;
        end else if (active && word_end && word_idx == 6'h01) begin
            exp_valid <= 1'b1;
            exp_cnt   <= 11'(({1'b0, read_frame ? (read_cmd.count_m1 > 5'h01 ? {1'b0, read_cmd.count_m1} + 6'h03
                          : `NORMAL_WORDS) : 6'h00} > {1'b0, data_words_in} ?
                          {1'b0, read_cmd.count_m1 > 5'h01 ? {1'b0, read_cmd.count_m1} + 6'h03 : `NORMAL_WORDS}
                          : {1'b0, data_words_in}) * (word_len_32 ? 11'd32 : 11'd24));
        end
    end

    // clock pulses counted regardless of frame completion
    always_ff @(posedge clk_sys) begin
        if (sys_rst || cs_fall)
            clk_cnt <= 11'h0;
        else if (cs_low && sclk_fall && clk_cnt != 11'h7ff)
            clk_cnt <= clk_cnt + 11'h1;
    end

    // select timeout counter
    always_ff @(posedge clk_sys) begin
        if (sys_rst || cs_fall) begin
            to_cnt    <= 32'h0;
            timed_out <= 1'b0;
        end else if (cs_low && timeout_en && !timed_out) begin
            to_cnt <= to_cnt + 32'h1;
            if (to_cnt == 32'(TIMEOUT_CYCLES) - 32'h1)
                timed_out <= 1'b1;
        end
    end

    // fault flags reported for the frame that just ended, set at select rise
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            clock_count_fault_flag    <= 1'b0;
            select_timeout_fault_flag <= 1'b0;
        end else if (cs_rise) begin
            clock_count_fault_flag    <= clock_counter_en && (!exp_valid || clk_cnt != exp_cnt);
            select_timeout_fault_flag <= timed_out;
        end
    end

    // readout progress: channel b word fully shifted
    assign frame_done = active && word_end && word_idx == 6'h02 && !read_frame;
    always_ff @(posedge clk_sys) begin
        if (sys_rst || cs_fall)
            chan_b_done <= 1'b0;
        else if (frame_done)
            chan_b_done <= 1'b1;
    end
    assign busy_read = cs_low && !read_frame && !chan_b_done;

    // conversion result buffering
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            out_buf    <= '0;
            hold_buf   <= '0;
            hold_valid <= 1'b0;
        end else begin
            if ((conv_done_a || conv_done_b) && busy_read) begin
                hold_buf   <= conv_in;
                hold_valid <= 1'b1;
            end else if (conv_done_a || conv_done_b) begin
                out_buf    <= conv_in;
                hold_valid <= 1'b0;
            end else if (hold_valid && cs_fall) begin
                out_buf    <= hold_buf;
                hold_valid <= 1'b0;
            end
        end
    end

    // data ready: low on new result, high once read or start written
    logic sel_done;
    assign sel_done = data_ready_source_select ? conv_done_b : conv_done_a;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            data_ready_out  <= 1'b1;
            drdy_pulse_pend <= 1'b0;
            drh_cnt         <= 8'h00;
        end else if (drdy_pulse_pend) begin
            data_ready_out <= 1'b1;
            if (drh_cnt == 8'(`DRH_WIDTH_CYC) - 8'h01) begin
                data_ready_out  <= 1'b0;
                drdy_pulse_pend <= 1'b0;
            end else begin
                drh_cnt <= drh_cnt + 8'h01;
            end
        end else if (sel_done) begin
            if (!data_ready_out) begin
                drdy_pulse_pend <= 1'b1;
                drh_cnt         <= 8'h00;
                data_ready_out  <= 1'b1;
            end else begin
                data_ready_out <= 1'b0;
            end
        end else if (frame_done && !hold_valid) begin
            data_ready_out <= 1'b1;
        end else if (start_seen && write_exec_pulse) begin
            data_ready_out <= 1'b1;
        end
    end
endmodule // adc_spi_frame_readout_control

// ---- bench/spi_host_model.sv ----
/*
 * host master model: drives serial clock, select and data, captures device data.
 * assumes clock mode 1 with clock idle low and a device clock far faster than sclk.
 */
`timescale 1ns/100ps
module spi_host_model (
    output logic      sclk,
    output logic      cs_low,
    output logic      sdi,
    input  wire logic sdo
);
    logic [31:0] rx [8];

    initial begin
        sclk = 1'b0;
        cs_low = 1'b1;
        sdi = 1'b0;
    end

    function automatic logic [15:0] crc(input logic [31:0] w, input int wl);
        logic [15:0] c;
        c = 16'hffff;
        for (int i = wl - 1; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? 16'h1021 : 16'h0000);
        return c;
    endfunction

    // word 0 command, word 1 its crc, then zero words as a no-op would send
    task automatic frame(input logic [15:0] cmd, input int wl, input int bits, input int hold);
        logic [31:0] w0;
        logic [31:0] w1;
        w0 = {16'h0000, cmd} << (wl - 16);
        w1 = {16'h0000, crc(w0, wl)} << (wl - 16);
        foreach (rx[k])
            rx[k] = 32'h0000_0000;
        cs_low = 1'b0;
        #200;
        for (int i = 0; i < bits; i++) begin
            sdi = (i < wl) ? w0[wl - 1 - i] : (i < 2 * wl) ? w1[2 * wl - 1 - i] : 1'b0;
            sclk = 1'b1;
            #80;
            if (i / wl < 8)
                rx[i / wl][wl - 1 - i % wl] = sdo;
            sclk = 1'b0;
            #80;
        end
        #(hold);
        cs_low = 1'b1;
        // released line must not keep looking driven
        sdi = ~sdi;
        #400;
    endtask
endmodule // spi_host_model

// ---- bench/adc_spi_frame_readout_control_checker.sv ----
/*
 * port-level checks of faults, command pulses and data ready.
 * assumes binding into the block, select and clock seen as raw pins.
 */
`timescale 1ns/100ps
module adc_spi_frame_readout_control_checker #(
    parameter int TIMEOUT_CYCLES = 2000
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic sclk_pin,
    input wire logic chip_select_low,
    input wire logic data_ready_out,
    input wire logic word_len_32,
    input wire logic clock_counter_en,
    input wire logic timeout_en,
    input wire logic data_ready_source_select,
    input wire logic conv_done_a,
    input wire logic conv_done_b,
    input wire logic clock_count_fault_flag,
    input wire logic select_timeout_fault_flag,
    input wire logic lock_pulse,
    input wire logic unlock_pulse,
    input wire logic reset_pulse,
    input wire logic write_exec_pulse
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic        sclk_q;
    logic [31:0] low_cyc;
    logic [15:0] edges;
    logic [5:0]  wl;
    logic        off_word;
    assign wl = word_len_32 ? 6'h20 : 6'h18;
    assign off_word = (edges % {10'h000, wl}) != 16'h0000;
    always_ff @(posedge clk_sys) begin
        sclk_q <= sclk_pin;
    end
    // counts hold their frame values at the edge that first sees select high
    always_ff @(posedge clk_sys) begin
        if (chip_select_low) begin
            low_cyc <= 32'h0;
            edges <= 16'h0;
        end else begin
            low_cyc <= low_cyc + 32'h1;
            edges <= edges + {15'h0, sclk_pin & ~sclk_q};
        end
    end
    sequence s_end;
        $rose(chip_select_low);
    endsequence
    sequence s_done;
        (data_ready_source_select ? conv_done_b : conv_done_a) && chip_select_low;
    endsequence
    sequence s_high;
        data_ready_out [*8];
    endsequence
    a_one_command: assert property ($onehot0({lock_pulse, unlock_pulse, reset_pulse, write_exec_pulse}))
        else $error("command pulses overlap");
    a_count_partial: assert property (s_end and clock_counter_en && off_word |-> ##[1:6] clock_count_fault_flag)
        else $error("partial word count not flagged");
    a_count_short: assert property (s_end and clock_counter_en && edges < 4 * wl |-> ##[1:6] clock_count_fault_flag)
        else $error("short frame not flagged");
    a_count_off: assert property (s_end and !clock_counter_en |-> ##[1:6] !clock_count_fault_flag)
        else $error("disabled counter flagged");
    a_timeout_long: assert property (s_end and timeout_en && low_cyc > TIMEOUT_CYCLES + 8 |-> ##[1:6] select_timeout_fault_flag)
        else $error("long select not flagged");
    a_timeout_short: assert property (s_end and low_cyc < TIMEOUT_CYCLES - 8 |-> ##[1:6] !select_timeout_fault_flag)
        else $error("short select flagged");
    a_flags_between: assert property ($changed(clock_count_fault_flag) || $changed(select_timeout_fault_flag) |-> chip_select_low)
        else $error("fault flag moved inside a frame");
    a_ready_falls: assert property (s_done and data_ready_out |-> ##[1:6] !data_ready_out)
        else $error("data ready did not fall");
    a_ready_pulse: assert property (s_done and !data_ready_out |-> ##[1:6] s_high ##[1:50] !data_ready_out)
        else $error("data ready high pulse missing");
endmodule // adc_spi_frame_readout_control_checker

bind adc_spi_frame_readout_control adc_spi_frame_readout_control_checker #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) chk_u (
    .clk_sys, .sys_rst, .sclk_pin, .chip_select_low, .data_ready_out, .word_len_32,
    .clock_counter_en, .timeout_en, .data_ready_source_select, .conv_done_a, .conv_done_b,
    .clock_count_fault_flag, .select_timeout_fault_flag, .lock_pulse, .unlock_pulse,
    .reset_pulse, .write_exec_pulse
);

// ---- bench/tb_adc_spi_frame_readout_control.sv ----
/*
 * self-checking bench: host model frames, register read back, faults and data ready.
 * assumes a 100 MHz clk_sys and a 160 ns serial clock from the host model.
 */
`timescale 1ns/100ps
module tb_adc_spi_frame_readout_control;
    logic                        clk_sys = 1'b0;
    logic                        sys_rst = 1'b1;
    logic                        sclk_pin, chip_select_low, sdi_pin, sdo_pin, data_ready_out;
    logic                        word_len_32, clock_counter_en, timeout_en, conv_done_a;
    logic                        cc_flag, to_flag, lock_pulse;
    logic [7:0]                  reg_addr;
    logic [3:0]                  cmd_response;
    spi_frame_pkg::conv_result_s conv_in;
    int                          errors = 0;
    int                          checked = 0;
    int                          cyc = 0;
    int                          locks = 0;

    always #5 clk_sys = ~clk_sys;

    spi_host_model host_u (.sclk(sclk_pin), .cs_low(chip_select_low), .sdi(sdi_pin), .sdo(sdo_pin));

    adc_spi_frame_readout_control #(.TIMEOUT_CYCLES(2000)) dut_u (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .sclk_pin(sclk_pin), .chip_select_low(chip_select_low),
        .sdi_pin(sdi_pin), .sdo_pin(sdo_pin), .data_ready_out(data_ready_out), .word_len_32(word_len_32),
        .crc_ansi(1'b0), .clock_counter_en(clock_counter_en), .timeout_en(timeout_en),
        .data_ready_source_select(1'b0), .conv_done_a(conv_done_a), .conv_done_b(1'b0), .conv_in(conv_in),
        .conversion_start_bit(1'b0), .reg_addr(reg_addr), .reg_data({reg_addr, ~reg_addr}),
        .reg_valid(reg_addr < 8'h20), .clock_count_fault_flag(cc_flag), .select_timeout_fault_flag(to_flag),
        .lock_pulse(lock_pulse), .unlock_pulse(), .reset_pulse(), .write_exec_pulse(), .write_cmd_word(),
        .cmd_response(cmd_response)
    );

    always @(posedge clk_sys) begin
        locks <= locks + int'(lock_pulse === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            errors++;
            report_and_stop();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic run(input logic [15:0] cmd, input int bits, input int hold);
        host_u.frame(cmd, word_len_32 ? 32 : 24, bits, hold);
        repeat (10) @(posedge clk_sys);
        #1;
    endtask

    task automatic t_read_back;
        run({3'h5, 8'h1e, 5'h02}, 96, 0);
        chk("read response", 32'h5, {28'h0, cmd_response});
        run(16'h0000, 120, 0);
        chk("reg 1e word", 32'h1ee11e, host_u.rx[1]);
        chk("reg 1f word", 32'h1fe01f, host_u.rx[2]);
        chk("invalid reg word", 32'h0, host_u.rx[3]);
        chk("long frame count", 32'h0, {31'h0, cc_flag});
    endtask

    task automatic t_read_then_lock;
        int n;
        run({3'h5, 8'h10, 5'h00}, 96, 0);
        n = locks;
        run(16'h0555, 96, 0);
        chk("lock after read", n, locks);
        chk("aux step 0 word", 32'h10ef10, host_u.rx[1]);
    endtask

    task automatic t_short_lock;
        int n;
        n = locks;
        run(16'h0555, 48, 0);
        chk("short lock runs", n + 1, locks);
        chk("short count flag", 32'h1, {31'h0, cc_flag});
        run(16'h0655, 96, 0);
        chk("full count flag", 32'h0, {31'h0, cc_flag});
    endtask

    task automatic t_clock_count;
        run(16'h0000, 100, 0);
        chk("extra clocks flag", 32'h1, {31'h0, cc_flag});
        chk("extra clocks response", 32'h0, {28'h0, cmd_response});
        clock_counter_en = 1'b0;
        run(16'h0000, 100, 0);
        chk("counter off flag", 32'h0, {31'h0, cc_flag});
        clock_counter_en = 1'b1;
        word_len_32 = 1'b1;
        run(16'h0000, 128, 0);
        chk("32-bit frame flag", 32'h0, {31'h0, cc_flag});
        run(16'h0000, 96, 0);
        chk("32-bit short flag", 32'h1, {31'h0, cc_flag});
        word_len_32 = 1'b0;
    endtask

    task automatic t_timeout;
        int n;
        timeout_en = 1'b1;
        run(16'h0000, 96, 25000);
        chk("late timeout flag", 32'h1, {31'h0, to_flag});
        chk("late timeout count", 32'h0, {31'h0, cc_flag});
        n = locks;
        run(16'h0555, 24, 25000);
        chk("cut lock ignored", n, locks);
        run(16'h0000, 96, 0);
        chk("fresh frame flag", 32'h0, {31'h0, to_flag});
        timeout_en = 1'b0;
    endtask

    task automatic t_ready;
        conv_in = {24'h123456, 24'h654321, 2'h1, 2'h1};
        repeat (2) begin
            @(posedge clk_sys);
            #1 conv_done_a = 1'b1;
            @(posedge clk_sys);
            #1 conv_done_a = 1'b0;
            repeat (80) @(posedge clk_sys);
        end
        chk("ready after result", 32'h0, {31'h0, data_ready_out});
        run(16'h0000, 48, 0);
        chk("ready after short read", 32'h0, {31'h0, data_ready_out});
        repeat (2) begin
            run(16'h0000, 96, 0);
            chk("ready after full read", 32'h1, {31'h0, data_ready_out});
            chk("channel a word", 32'h123456, host_u.rx[1]);
            chk("channel b word", 32'h654321, host_u.rx[2]);
        end
    endtask

    task automatic report_and_stop;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        word_len_32 = 1'b0;
        clock_counter_en = 1'b1;
        timeout_en = 1'b0;
        conv_done_a = 1'b0;
        conv_in = '0;
        repeat (3) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        repeat (4) @(posedge clk_sys);
        t_read_back();
        t_read_then_lock();
        t_short_lock();
        t_clock_count();
        t_timeout();
        t_ready();
        report_and_stop();
    end
endmodule // tb_adc_spi_frame_readout_control
